// ==== verilog/idw_pkg.sv ====
package idw_pkg;
    // Word indices handled by this block
    localparam logic [7:0] IDW_W_CAP = 8'h31;        // 49
    localparam logic [7:0] IDW_W_VALID = 8'h35;      // 53
    localparam logic [7:0] IDW_W_MWDMA = 8'h3f;      // 63
    localparam logic [7:0] IDW_W_PIO = 8'h40;        // 64
    localparam logic [7:0] IDW_W_CYC_FIRST = 8'h41;  // 65
    localparam logic [7:0] IDW_W_CYC_LAST = 8'h44;   // 68
    localparam logic [7:0] IDW_W_QDEPTH = 8'h4b;     // 75
    localparam logic [7:0] IDW_W_LCAP = 8'h4c;       // 76
    localparam logic [7:0] IDW_W_LADD = 8'h4d;       // 77
    localparam logic [7:0] IDW_W_FSUP = 8'h4e;       // 78
    localparam logic [7:0] IDW_W_FEN = 8'h4f;        // 79
    localparam logic [7:0] IDW_W_UDMA = 8'h58;       // 88
    localparam logic [7:0] IDW_W_HWRST = 8'h5d;      // 93
    localparam logic [7:0] IDW_W_TMAJ = 8'hde;       // 222
    // Field positions
    localparam int IDW_CAP_FLOW_BIT = 11;
    localparam int IDW_CAP_FLOWDIS_BIT = 10;
    localparam int IDW_VALID_UDMA_BIT = 2;
    localparam int IDW_VALID_CYC_BIT = 1;
    localparam int IDW_LADD_SPEED_LSB = 1;
    localparam int IDW_TMAJ_TYPE_LSB = 12;
    // Constant values
    localparam logic [15:0] IDW_CYCLE_NS = 16'h0078; // 120 ns
    localparam logic [3:0] IDW_TTYPE_SERIAL = 4'h1;
    localparam logic [15:0] IDW_NO_VERSION = 16'hffff;
    localparam logic [15:0] IDW_ZERO = 16'h0000;
    localparam logic [15:0] IDW_RST_WORD = 16'h0000;
endpackage

// ==== verilog/idw_word_builder.sv ====
`timescale 1ns/100ps
module idw_word_builder
#(
    parameter logic [2:0] MWDMA_MODES = 3'h7,
    parameter logic [1:0] PIO_MODES = 2'h3,
    parameter logic [5:0] UDMA_MODES = 6'h3f,
    parameter logic [4:0] QUEUE_DEPTH_M1 = 5'h1f,
    parameter logic [2:0] SPEEDS = 3'h7,
    parameter logic [7:0] LCAP_FLAGS = 8'h01,
    parameter logic [5:0] LADD_FLAGS = 6'h00,
    parameter logic [11:0] FSUP_FLAGS = 12'h000,
    parameter bit REPORT_VERSION = 1'b1,
    parameter logic [10:0] REV_FLAGS = 11'h400
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Word request
    input wire logic rd_req,
    input wire logic [7:0] rd_index,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // Command-set defined word source
    input wire logic [15:0] ext_word,
    // Removable media
    input wire logic media_changed,
    // Live device state
    input wire logic [2:0] cur_speed,
    input wire logic [10:0] feat_enabled
);
    import idw_pkg::*;

    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic rd_valid_q;
    logic [2:0] mwdma_q;
    logic [1:0] pio_q;
    logic [5:0] udma_q;
    logic load_q;

    // Fixed mode flags are latched once after reset and again only on a media change
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            load_q <= 1'b1;
            mwdma_q <= 3'h0;
            pio_q <= 2'h0;
            udma_q <= 6'h00;
        end
        else
        begin
            load_q <= 1'b0;
            if (load_q || media_changed)
            begin
                mwdma_q <= MWDMA_MODES;
                pio_q <= PIO_MODES;
                udma_q <= UDMA_MODES;
            end
        end
    end

    // Assembled words
    wire [15:0] w_cap = {ext_word[15:12], 1'b1, 1'b1, ext_word[9:0]};
    wire udma_ok = |udma_q;
    wire cyc_ok = |pio_q;
    wire [15:0] w_valid = {13'h0000, udma_ok, cyc_ok, 1'b0};
    wire [15:0] w_mwdma = {ext_word[15:3], mwdma_q};
    wire [15:0] w_pio = {ext_word[15:2], pio_q};
    wire [15:0] w_qdepth = {11'h000, QUEUE_DEPTH_M1};
    wire [15:0] w_lcap = {LCAP_FLAGS, 4'h0, SPEEDS, 1'b0};
    wire [15:0] w_ladd = {6'h00, LADD_FLAGS, cur_speed, 1'b0};
    wire [15:0] w_fsup = {3'h0, FSUP_FLAGS, 1'b0};
    wire [15:0] w_fen = {4'h0, feat_enabled, 1'b0};
    wire [15:0] w_udma = {ext_word[15:6], udma_q};
    wire [15:0] w_tmaj = REPORT_VERSION ? {IDW_TTYPE_SERIAL, 1'b0, REV_FLAGS} : IDW_NO_VERSION;
    wire is_cyc = (rd_index >= IDW_W_CYC_FIRST) && (rd_index <= IDW_W_CYC_LAST);

    // Word selection; unlisted indices pass through
    always_comb
    begin
        rd_data_d = ext_word;
        if (is_cyc)
            rd_data_d = IDW_CYCLE_NS;
        else
        begin
            unique case (rd_index)
                IDW_W_CAP: rd_data_d = w_cap;
                IDW_W_VALID: rd_data_d = w_valid;
                IDW_W_MWDMA: rd_data_d = w_mwdma;
                IDW_W_PIO: rd_data_d = w_pio;
                IDW_W_QDEPTH: rd_data_d = w_qdepth;
                IDW_W_LCAP: rd_data_d = w_lcap;
                IDW_W_LADD: rd_data_d = w_ladd;
                IDW_W_FSUP: rd_data_d = w_fsup;
                IDW_W_FEN: rd_data_d = w_fen;
                IDW_W_UDMA: rd_data_d = w_udma;
                IDW_W_HWRST: rd_data_d = IDW_ZERO;
                IDW_W_TMAJ: rd_data_d = w_tmaj;
                default: rd_data_d = ext_word;
            endcase
        end
    end

    // Registered answer one cycle after the request
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rd_data_q <= IDW_RST_WORD;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= rd_req;
            if (rd_req)
                rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;

    // Every read check looks one edge after the request, when the registered answer stands
    // Checks on fixed words compare against parameters, written-out constants or the latched mode flags so a wrong packing shows at once
    // Word indices are written out, except in the two live-word checks, so a package typo cannot hide behind itself

    a_speed_live: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == IDW_W_LADD |=> rd_valid && rd_data[3:1] == $past(cur_speed))
        else $error("negotiated speed field wrong");
    a_enable_live: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == IDW_W_FEN |=> rd_data == {4'h0, $past(feat_enabled), 1'b0})
        else $error("enabled flags word wrong");
    a_cycle_time: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index >= 8'h41 && rd_index <= 8'h44 |=> rd_data == 16'h0078)
        else $error("cycle time word not 120 ns");
    a_hwreset_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h5d |=> rd_data == 16'h0000)
        else $error("reset result word not zero");
    a_cap_flow: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h31 |=> rd_data[11:10] == 2'h3 && rd_data[9:0] == $past(ext_word[9:0]))
        else $error("capability flow bits wrong");
    a_valid_word: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h35 |=> rd_data[15:3] == 13'h0000 && rd_data[2] == |udma_q)
        else $error("field validity word wrong");
    a_lcap_resv: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4c |=> rd_data[7:4] == 4'h0 && !rd_data[0])
        else $error("link capability reserved bits set");
    a_pass_through: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h00 |=> rd_data == $past(ext_word))
        else $error("external word not passed");
    a_fixed_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(load_q) && !$past(media_changed) |-> $stable(udma_q) && $stable(mwdma_q))
        else $error("fixed flags changed without media change");
    a_tmaj_form: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'hde |=> rd_data == 16'hffff || (rd_data[15:12] == 4'h1 && !rd_data[11]))
        else $error("transport major word malformed");

    // Each taken request yields exactly one answer marker
    a_valid_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req |=> rd_valid)
        else $error("answer marker missing");

    // No marker without a request
    a_valid_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        !rd_req |=> !rd_valid)
        else $error("answer marker without request");

    // Data holds between reads so a slow reader still sees its word
    a_data_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !rd_req |=> $stable(rd_data))
        else $error("answer changed without request");

    // Reset clears the answer path
    a_reset_quiet: assert property (@(posedge mclk)
        !rst_b |=> !rd_valid && rd_data == 16'h0000)
        else $error("answer path not cleared by reset");

    // Word 53 bit 1 follows the programmed mode flags
    a_valid_cyc: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h35 |=> rd_data[1] == (|pio_q))
        else $error("timing valid flag wrong");

    // Word 53 obsolete bit is kept at zero
    a_valid_bit0: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h35 |=> !rd_data[0])
        else $error("field validity bit 0 set");

    // Word 63 low bits from the latched flags, upper bits from outside
    a_mwdma_flags: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h3f |=> rd_data[2:0] == mwdma_q && rd_data[15:3] == $past(ext_word[15:3]))
        else $error("multiword mode word wrong");

    // Word 64 low bits from the latched flags, upper bits from outside
    a_pio_flags: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h40 |=> rd_data[1:0] == pio_q && rd_data[15:2] == $past(ext_word[15:2]))
        else $error("programmed mode word wrong");

    // Word 62 sits just below the mode words and passes through
    a_below_modes: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h3e |=> rd_data == $past(ext_word))
        else $error("word 62 not passed");

    // Word 66 is one of the fixed cycle times
    a_cycle_mid: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h42 |=> rd_data == 16'h0078)
        else $error("word 66 cycle time wrong");

    // Word 69 lies past the cycle range; an off-by-one in the range shows here
    a_cycle_above: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h45 |=> rd_data == $past(ext_word))
        else $error("word 69 not passed");

    // Word 75 carries depth minus one and nothing above
    a_qdepth_word: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4b |=> rd_data[15:5] == 11'h000 && rd_data[4:0] == QUEUE_DEPTH_M1)
        else $error("queue depth word wrong");

    // Word 74 is outside and passes through
    a_qdepth_below: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4a |=> rd_data == $past(ext_word))
        else $error("word 74 not passed");

    // Word 76 speed flags
    a_lcap_speed: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4c |=> rd_data[3:1] == SPEEDS)
        else $error("link speed flags wrong");

    // Word 76 must never look like an absent word to the host
    a_lcap_present: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4c |=> rd_data != 16'h0000 && rd_data != 16'hffff)
        else $error("link capability word looks absent");

    // Word 76 feature flags
    a_lcap_feat: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4c |=> rd_data[15:8] == LCAP_FLAGS)
        else $error("link feature flags wrong");

    // Word 77 reserved bits
    a_ladd_resv: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4d |=> rd_data[15:10] == 6'h00 && !rd_data[0])
        else $error("additional capability reserved bits set");

    // Word 77 fixed capability flags
    a_ladd_caps: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4d |=> rd_data[9:4] == LADD_FLAGS)
        else $error("additional capability flags wrong");

    // Word 78 is entirely fixed
    a_fsup_word: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4e |=> rd_data == {3'h0, FSUP_FLAGS, 1'b0})
        else $error("supported features word wrong");

    // Word 79 reserved bits
    a_fen_resv: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4f |=> rd_data[15:12] == 4'h0 && !rd_data[0])
        else $error("enabled features reserved bits set");

    // Top enable flag lands on word bit 11
    a_fen_top: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4f |=> rd_data[11] == $past(feat_enabled[10]))
        else $error("top enable flag misplaced");

    // Lowest enable flag lands on word bit 1
    a_fen_low: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h4f |=> rd_data[1] == $past(feat_enabled[0]))
        else $error("lowest enable flag misplaced");

    // Word 88 low bits from the latched flags, upper bits from outside
    a_udma_flags: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h58 |=> rd_data[5:0] == udma_q && rd_data[15:6] == $past(ext_word[15:6]))
        else $error("ultra mode word wrong");

    // Word 92 just below the reset result word passes through
    a_below_hwrst: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h5c |=> rd_data == $past(ext_word))
        else $error("word 92 not passed");

    // Word 222 matches the chosen reporting form
    a_tmaj_value: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'hde |=> rd_data == (REPORT_VERSION ? {4'h1, 1'b0, REV_FLAGS} : 16'hffff))
        else $error("transport major word value wrong");

    // Word 223 belongs to outside logic
    a_tmaj_minor: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'hdf |=> rd_data == $past(ext_word))
        else $error("word 223 not passed");

    // Word 49 upper field comes from outside
    a_cap_upper: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h31 |=> rd_data[15:12] == $past(ext_word[15:12]))
        else $error("capability upper field wrong");

    // Highest index passes through
    a_pass_high: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'hff |=> rd_data == $past(ext_word))
        else $error("word 255 not passed");

    // A word in the middle of the outside range passes through
    a_pass_mid: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_req && rd_index == 8'h64 |=> rd_data == $past(ext_word))
        else $error("word 100 not passed");

    // Load strobe lasts one cycle, so fixed flags settle right after reset
    a_load_once: assert property (@(posedge mclk) disable iff (!rst_b)
        load_q |=> !load_q)
        else $error("load strobe stuck");

    // Once loaded, the fixed flags hold their documented values
    a_fixed_value: assert property (@(posedge mclk) disable iff (!rst_b)
        !load_q |-> udma_q == UDMA_MODES && mwdma_q == MWDMA_MODES && pio_q == PIO_MODES)
        else $error("fixed flags differ from parameters");

    // Programmed mode flags never drift outside a media change
    a_fixed_pio: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(load_q) && !$past(media_changed) |-> $stable(pio_q))
        else $error("programmed flags changed without media change");

    // A media change reloads the flags on the next edge
    a_media_reload: assert property (@(posedge mclk) disable iff (!rst_b)
        media_changed |=> udma_q == UDMA_MODES)
        else $error("media change did not reload flags");
endmodule // idw_word_builder

// ==== verif/idw_ext_model.sv ====
`timescale 1ns/100ps
// Command-set word source; the pattern differs per index so a wrong pass-through shows
module idw_ext_model
(
    // Index from the reader
    input wire logic [7:0] rd_index,
    // Word offered to the builder in the request cycle
    output logic [15:0] ext_word
);
    assign ext_word = {rd_index, rd_index ^ 8'ha5};
endmodule // idw_ext_model

// ==== verif/tb.sv ====
`timescale 1ns/100ps
module tb;
    import idw_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic rd_req = 1'b0;
    logic [7:0] rd_index = 8'h00;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] ext_word;
    logic media_changed = 1'b0;
    logic [2:0] cur_speed = 3'h0;
    logic [10:0] feat_enabled = 11'h000;
    logic [2:0] spd_v = 3'h0;
    logic [10:0] fe_v = 11'h000;
    int err_total = 0;
    int comparisons = 0;
    idw_word_builder i_idw_word_builder (.mclk(mclk), .rst_b(rst_b), .rd_req(rd_req), .rd_index(rd_index),
        .rd_data(rd_data), .rd_valid(rd_valid), .ext_word(ext_word), .media_changed(media_changed),
        .cur_speed(cur_speed), .feat_enabled(feat_enabled));
    idw_ext_model i_idw_ext_model (.rd_index(rd_index), .ext_word(ext_word));
    // 50 ns clock
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    // Same pattern as the model, worked out here independently
    function automatic logic [15:0] ex(input logic [7:0] i);
        return {i, i ^ 8'ha5};
    endfunction
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One read: live state changes at the request edge, answer checked one cycle later
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        @(posedge mclk);
        rd_req <= 1'b1;
        rd_index <= idx;
        cur_speed <= spd_v;
        feat_enabled <= fe_v;
        @(posedge mclk);
        rd_req <= 1'b0;
        #1;
        chk("valid", {15'h0, rd_valid}, 16'h0001);
        chk($sformatf("word %0d", idx), rd_data, exp);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog so a hang still reaches the verdict
    initial
    begin
        #2ms;
        err_total++;
        print_verdict();
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(IDW_W_CAP, ex(IDW_W_CAP) | 16'h0c00);
        rd(IDW_W_VALID, 16'h0006);
        rd(IDW_W_MWDMA, (ex(IDW_W_MWDMA) & 16'hfff8) | 16'h0007);
        rd(IDW_W_PIO, (ex(IDW_W_PIO) & 16'hfffc) | 16'h0003);
        for (int i = 65; i <= 68; i++)
            rd(8'(i), 16'h0078);
        rd(IDW_W_QDEPTH, 16'h001f);
        rd(IDW_W_LCAP, 16'h010e);
        rd(IDW_W_FSUP, 16'h0000);
        rd(IDW_W_UDMA, (ex(IDW_W_UDMA) & 16'hffc0) | 16'h003f);
        rd(IDW_W_HWRST, 16'h0000);
        rd(IDW_W_TMAJ, 16'h1400);
        rd(8'h2f, ex(8'h2f));
        rd(8'h64, ex(8'h64));
        rd(8'h00, ex(8'h00));
        rd(8'hff, ex(8'hff));
        $display("Test fixed words done");
        // Live speed and enable state must show on the very next read
        for (int s = 1; s <= 3; s++)
        begin
            spd_v = 3'(s);
            rd(IDW_W_LADD, {12'h0, 3'(s), 1'b0});
        end
        fe_v = 11'h7ff;
        rd(IDW_W_FEN, 16'h0ffe);
        fe_v = 11'h400;
        rd(IDW_W_FEN, 16'h0800);
        $display("Test live words done");
        // Back to back requests, then the answer marker must drop
        @(posedge mclk);
        rd_req <= 1'b1;
        rd_index <= IDW_W_LCAP;
        @(posedge mclk);
        rd_index <= IDW_W_LADD;
        #1 chk("b2b first", rd_data, 16'h010e);
        @(posedge mclk);
        rd_req <= 1'b0;
        #1 chk("b2b second", rd_data, 16'h0006);
        @(posedge mclk);
        #1 chk("valid drop", {15'h0, rd_valid}, 16'h0000);
        // Media change reloads fixed flags to the same values
        @(posedge mclk);
        media_changed <= 1'b1;
        @(posedge mclk);
        media_changed <= 1'b0;
        rd(IDW_W_MWDMA, (ex(IDW_W_MWDMA) & 16'hfff8) | 16'h0007);
        rd(IDW_W_VALID, 16'h0006);
        $display("Test sequence and media done");
        print_verdict();
    end
endmodule // tb
